/* File: rtl/pmb_basic_control.sv */
// Management register bank with reset, loopback and speed control
`timescale 1ns/1ps
module pmb_basic_control
   import pmb_pkg::*;
#(
   parameter logic [15:0] ID_HIGH = 16'h1a2b, // Arbitrary value
   parameter logic [15:0] ID_LOW = 16'h3c4d // Arbitrary value
)
(
   input wire logic SYS_CLK,
   input wire logic RESET,
   input wire logic CE,
   input wire logic MDC,
   input wire logic MDIO_I,
   output logic MDIO_O,
   output logic MDIO_OE_N,
   input wire logic [4:0] PHY_ADDR,
   input wire logic AN_PIN_EN,
   input wire logic FX_MODE,
   input wire logic NEG_SPEED_100,
   input wire logic NEG_FULL_DUPLEX,
   input wire logic [3:0] TXD,
   input wire logic TXEN,
   input wire logic [3:0] RXD_PHY,
   input wire logic RXDV_PHY,
   output logic [3:0] RXD,
   output logic RXDV,
   output logic LOOPBACK,
   output logic SPEED_100,
   output logic FULL_DUPLEX,
   output logic POWER_DOWN,
   output logic SRST_BUSY
);

   // ***********************************************
   // Helpers
   // ***********************************************
   // Register select; shared by write decode and checks
   function automatic logic reg_hit(input logic [4:0] a,
                                    input logic [4:0] r);
      reg_hit = (a == r);
   endfunction

   // ***********************************************
   // Strap synchronisers
   // ***********************************************
   logic [6:0] cfg_s1_reg; // First stage, read only by second
   logic [6:0] cfg_s2_reg; // Safe stage
   logic [4:0] phy_addr_s; // Our station address
   logic an_pin_s; // Hardware negotiation permit
   logic fx_s; // Fiber mode

   // Straps come from pins, so they pass two flops
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         cfg_s1_reg <= 7'h00;
         cfg_s2_reg <= 7'h00;
      end else if (CE) begin
         cfg_s1_reg <= {PHY_ADDR, AN_PIN_EN, FX_MODE};
         cfg_s2_reg <= cfg_s1_reg;
      end
   end

   assign phy_addr_s = cfg_s2_reg[6:2];
   assign an_pin_s = cfg_s2_reg[1];
   assign fx_s = cfg_s2_reg[0];

   // ***********************************************
   // Frame engine
   // ***********************************************
   pmb_mgmt_if mif(); // Strobes between engine and bank

   pmb_mdio_engine u_engine (
      .clk(SYS_CLK),
      .rst(RESET),
      .ce(CE),
      .mdc(MDC),
      .mdio_i(MDIO_I),
      .phy_addr(phy_addr_s),
      .mdio_o(MDIO_O),
      .mdio_oe_n(MDIO_OE_N),
      .bus(mif)
   );

   // ***********************************************
   // Control state
   // ***********************************************
   logic [15:0] ctrl_reg, ctrl_next; // Stored control bits
   logic [15:0] adv_reg, adv_next; // Advertisement
   logic busy_reg, busy_next; // Software reset running
   logic [6:0] srst_cnt_reg, srst_cnt_next; // Reset interval
   logic an_active; // Negotiation really enabled
   logic wr_ctrl; // Write aimed at control
   logic wr_adv; // Write aimed at advertisement

   // Negotiation runs only with both bit and strap set
   assign an_active = ctrl_reg[CTRL_ANEN] & an_pin_s;
   assign wr_ctrl = mif.wr_stb && reg_hit(mif.addr, REG_CTRL);
   assign wr_adv = mif.wr_stb && reg_hit(mif.addr, REG_ADV);

   // Next control values
   always_comb begin
      ctrl_next = ctrl_reg;
      adv_next = adv_reg;
      busy_next = busy_reg;
      srst_cnt_next = srst_cnt_reg;
      // Interval runs out on its own, no second write
      if (busy_reg) begin
         srst_cnt_next = srst_cnt_reg + 7'h01;
         if (srst_cnt_reg == SRST_LAST) begin
            busy_next = 1'h0;
         end
      end
      // Busy blocks the whole control word
      if (wr_ctrl && !busy_reg) begin
         if (mif.wdata[CTRL_SRST]) begin
            // Defaults win over whatever else was written
            ctrl_next = CTRL_RESET;
            adv_next = ADV_RESET;
            busy_next = 1'h1;
            srst_cnt_next = 7'h00;
         end else begin
            // A zero reset bit just stores the CTRL_RW_MASK bits
            ctrl_next = mif.wdata & CTRL_RW_MASK;
            // Strap disable makes the enable bit deaf
            if (!an_pin_s) begin
               ctrl_next[CTRL_ANEN] = ctrl_reg[CTRL_ANEN];
            end
         end
      end
      if (wr_adv) begin
         adv_next = mif.wdata;
      end
      // Fiber pins the speed bit high
      if (fx_s) begin
         ctrl_next[CTRL_SPEED] = 1'h1;
      end
   end

   // Register control state
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         ctrl_reg <= CTRL_RESET;
         adv_reg <= ADV_RESET;
         busy_reg <= 1'h0;
         srst_cnt_reg <= 7'h00;
      end else if (CE) begin
         ctrl_reg <= ctrl_next;
         adv_reg <= adv_next;
         busy_reg <= busy_next;
         srst_cnt_reg <= srst_cnt_next;
      end
   end

   // ***********************************************
   // Data path and resolved mode
   // ***********************************************
   logic [3:0] rxd_reg, rxd_next; // Receive nibble out
   logic rxdv_reg, rxdv_next; // Receive valid out
   logic spd_reg, spd_next; // Operating speed
   logic dup_reg, dup_next; // Operating duplex

   // Loopback swaps the receive source; one flop of delay
   always_comb begin
      if (ctrl_reg[CTRL_LOOP]) begin
         rxd_next = TXD;
         rxdv_next = TXEN;
      end else begin
         rxd_next = RXD_PHY;
         rxdv_next = RXDV_PHY;
      end
      // Forced bits count only without negotiation
      if (an_active) begin
         spd_next = NEG_SPEED_100;
         dup_next = NEG_FULL_DUPLEX;
      end else begin
         spd_next = ctrl_reg[CTRL_SPEED];
         dup_next = ctrl_reg[CTRL_DUPLEX];
      end
   end

   // Register data path
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         rxd_reg <= 4'h0;
         rxdv_reg <= 1'h0;
         spd_reg <= 1'h1;
         dup_reg <= 1'h1;
      end else if (CE) begin
         rxd_reg <= rxd_next;
         rxdv_reg <= rxdv_next;
         spd_reg <= spd_next;
         dup_reg <= dup_next;
      end
   end

   // ***********************************************
   // Read mux
   // ***********************************************
   logic [15:0] rdata_reg, rdata_next; // Held read value
   logic [15:0] ctrl_view; // Control as software sees it
   logic dup_view; // Duplex as read back

   // Reset and restart bits read zero; speed shows forced value
   assign dup_view = an_active ? NEG_FULL_DUPLEX :
                     ctrl_reg[CTRL_DUPLEX];
   assign ctrl_view = {1'h0, ctrl_reg[CTRL_LOOP],
                       ctrl_reg[CTRL_SPEED] | fx_s,
                       ctrl_reg[CTRL_ANEN], ctrl_reg[CTRL_PDOWN],
                       2'h0, dup_view, 8'h00};

   // Captured on the strobe, long before the reply starts
   always_comb begin
      rdata_next = rdata_reg;
      if (mif.rd_stb) begin
         case (mif.addr)
            REG_CTRL: rdata_next = ctrl_view;
            REG_STAT: rdata_next = STAT_RESET;
            REG_IDH: rdata_next = ID_HIGH;
            REG_IDL: rdata_next = ID_LOW;
            REG_ADV: rdata_next = adv_reg;
            REG_LPA: rdata_next = LPA_RESET;
            REG_EXP: rdata_next = EXP_RESET;
            default: rdata_next = 16'h0000;
         endcase
      end
   end

   // Register read value
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         rdata_reg <= 16'h0000;
      end else if (CE) begin
         rdata_reg <= rdata_next;
      end
   end

   assign mif.rdata = rdata_reg;
   assign RXD = rxd_reg;
   assign RXDV = rxdv_reg;
   assign LOOPBACK = ctrl_reg[CTRL_LOOP];
   assign SPEED_100 = spd_reg;
   assign FULL_DUPLEX = dup_reg;
   assign POWER_DOWN = ctrl_reg[CTRL_PDOWN];
   assign SRST_BUSY = busy_reg;

   // ***********************************************
   // Checks
   // ***********************************************
   property p_defaults;
      @(posedge SYS_CLK) disable iff (RESET)
      $fell(RESET) |-> ctrl_reg == CTRL_RESET && adv_reg == ADV_RESET;
   endproperty
   a_defaults: assert property (p_defaults)
      else $error("defaults missing after reset");

   property p_stat_read;
      @(posedge SYS_CLK) disable iff (RESET)
      CE && mif.rd_stb && mif.addr == REG_STAT
      |=> rdata_reg == STAT_RESET;
   endproperty
   a_stat_read: assert property (p_stat_read)
      else $error("status read wrong");

   property p_lpa_read;
      @(posedge SYS_CLK) disable iff (RESET)
      CE && mif.rd_stb && mif.addr == REG_LPA
      |=> rdata_reg == LPA_RESET;
   endproperty
   a_lpa_read: assert property (p_lpa_read)
      else $error("partner read wrong");

   property p_srst_start;
      @(posedge SYS_CLK) disable iff (RESET)
      CE && wr_ctrl && !busy_reg && mif.wdata[CTRL_SRST]
      |=> busy_reg && ctrl_reg == CTRL_RESET && adv_reg == ADV_RESET;
   endproperty
   a_srst_start: assert property (p_srst_start)
      else $error("software reset did not restore");

   property p_srst_end;
      @(posedge SYS_CLK) disable iff (RESET)
      $rose(busy_reg) |-> ##[99:100] !busy_reg;
   endproperty
   a_srst_end: assert property (p_srst_end)
      else $error("reset bit did not self clear");

   property p_bit15_zero;
      @(posedge SYS_CLK) disable iff (RESET)
      CE && mif.rd_stb && reg_hit(mif.addr, REG_CTRL)
      |=> !rdata_reg[CTRL_SRST];
   endproperty
   a_bit15_zero: assert property (p_bit15_zero)
      else $error("reset bit read as one");

   property p_busy_hold;
      @(posedge SYS_CLK) disable iff (RESET)
      busy_reg && wr_ctrl |=> $stable(ctrl_reg[CTRL_LOOP]) &&
      $stable(ctrl_reg[CTRL_PDOWN]);
   endproperty
   a_busy_hold: assert property (p_busy_hold)
      else $error("control changed during reset");

   property p_loop;
      @(posedge SYS_CLK) disable iff (RESET)
      CE && ctrl_reg[CTRL_LOOP] |=> RXD == $past(TXD);
   endproperty
   a_loop: assert property (p_loop)
      else $error("loopback nibble lost");

   property p_loop_off;
      @(posedge SYS_CLK) disable iff (RESET)
      CE && wr_ctrl && !busy_reg && !mif.wdata[CTRL_LOOP]
      |=> !LOOPBACK;
   endproperty
   a_loop_off: assert property (p_loop_off)
      else $error("loopback did not end");

   property p_speed;
      @(posedge SYS_CLK) disable iff (RESET)
      CE |=> SPEED_100 == ($past(an_active) ? $past(NEG_SPEED_100) :
                           $past(ctrl_reg[CTRL_SPEED]));
   endproperty
   a_speed: assert property (p_speed)
      else $error("speed resolution wrong");

   property p_fx;
      @(posedge SYS_CLK) disable iff (RESET)
      CE && fx_s && mif.rd_stb && reg_hit(mif.addr, REG_CTRL)
      |=> rdata_reg[CTRL_SPEED];
   endproperty
   a_fx: assert property (p_fx)
      else $error("fiber speed bit not one");

endmodule

/* File: rtl/pmb_pkg.sv */
// Constants and types of the management register bank
package pmb_pkg;

   // ***********************************************
   // Register numbers
   // ***********************************************
   localparam logic [4:0] REG_CTRL = 5'h00;
   localparam logic [4:0] REG_STAT = 5'h01;
   localparam logic [4:0] REG_IDH = 5'h02;
   localparam logic [4:0] REG_IDL = 5'h03;
   localparam logic [4:0] REG_ADV = 5'h04;
   localparam logic [4:0] REG_LPA = 5'h05;
   localparam logic [4:0] REG_EXP = 5'h06;

   // ***********************************************
   // Reset values
   // ***********************************************
   localparam logic [15:0] CTRL_RESET = 16'h3100;
   localparam logic [15:0] STAT_RESET = 16'h7849;
   localparam logic [15:0] ADV_RESET = 16'h01e1;
   localparam logic [15:0] LPA_RESET = 16'h0080;
   localparam logic [15:0] EXP_RESET = 16'h0000;

   // ***********************************************
   // Control field positions
   // ***********************************************
   localparam int CTRL_SRST = 15; // Self clearing reset
   localparam int CTRL_LOOP = 14; // Loopback
   localparam int CTRL_SPEED = 13; // Forced speed
   localparam int CTRL_ANEN = 12; // Negotiation enable
   localparam int CTRL_PDOWN = 11; // Power down
   localparam int CTRL_DUPLEX = 8; // Forced duplex
   // Bits that are stored at all
   localparam logic [15:0] CTRL_RW_MASK = 16'h7900;

   // ***********************************************
   // Timing
   // ***********************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int SRST_TIME_NS = 1000;
   localparam int SRST_CYCLES = SRST_TIME_NS / CLK_PERIOD_NS;
   localparam logic [6:0] SRST_LAST = 7'(SRST_CYCLES - 1);

   // ***********************************************
   // Serial frame layout
   // ***********************************************
   localparam logic [5:0] PRE_LEN = 6'h20; // Preamble ones
   localparam logic [5:0] HDR_LAST = 6'h0c; // Header bits - 1
   localparam logic [5:0] DATA_LAST = 6'h0f; // Data bits - 1
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;

   // Frame engine states
   typedef enum logic [1:0] {
      PMB_PRE = 2'b00,
      PMB_HDR = 2'b01,
      PMB_TA = 2'b10,
      PMB_DATA = 2'b11
   } pmb_state_t;

endpackage

/* File: rtl/pmb_mgmt_if.sv */
// Register access strobes between frame engine and bank
`timescale 1ns/1ps
interface pmb_mgmt_if;
   logic rd_stb; // One cycle read request
   logic wr_stb; // One cycle write request
   logic [4:0] addr; // Register number
   logic [15:0] wdata; // Write value
   logic [15:0] rdata; // Read value, held until next read
   modport engine (output rd_stb, wr_stb, addr, wdata, input rdata);
   modport bank (input rd_stb, wr_stb, addr, wdata, output rdata);
endinterface

/* File: rtl/pmb_mdio_engine.sv */
// Serial management frame engine
`timescale 1ns/1ps
module pmb_mdio_engine
   import pmb_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic mdc,
   input wire logic mdio_i,
   input wire logic [4:0] phy_addr,
   output logic mdio_o,
   output logic mdio_oe_n,
   pmb_mgmt_if.engine bus
);

   // ***********************************************
   // Synchronisers
   // ***********************************************
   logic mdc_s1_reg, mdc_s2_reg, mdc_s3_reg; // Clock sync plus edge
   logic mdio_s1_reg, mdio_s2_reg; // Data sync
   logic mdc_rise; // One cycle per rising management clock
   logic bit_in; // Synchronised data bit

   // Two flops before use; the third only delays for the edge
   always_ff @(posedge clk) begin
      if (rst) begin
         mdc_s1_reg <= 1'h0;
         mdc_s2_reg <= 1'h0;
         mdc_s3_reg <= 1'h0;
         mdio_s1_reg <= 1'h1;
         mdio_s2_reg <= 1'h1;
      end else if (ce) begin
         mdc_s1_reg <= mdc;
         mdc_s2_reg <= mdc_s1_reg;
         mdc_s3_reg <= mdc_s2_reg;
         mdio_s1_reg <= mdio_i;
         mdio_s2_reg <= mdio_s1_reg;
      end
   end

   assign mdc_rise = mdc_s2_reg & ~mdc_s3_reg;
   assign bit_in = mdio_s2_reg;

   // ***********************************************
   // Frame state
   // ***********************************************
   pmb_state_t state_reg, state_next; // Frame phase
   logic [5:0] cnt_reg, cnt_next; // Bit counter
   logic [15:0] sh_reg, sh_next; // Shift register
   logic rd_reg, rd_next; // Frame is a read
   logic hit_reg, hit_next; // Frame addresses us
   logic out_reg, out_next; // Pin output level
   logic oe_n_reg, oe_n_next; // Pin released when high
   logic rds_reg, rds_next; // Read strobe
   logic wrs_reg, wrs_next; // Write strobe
   logic [4:0] addr_reg, addr_next; // Register number
   logic [15:0] wd_reg, wd_next; // Write data
   logic [12:0] hdr; // Header as completed by this bit

   assign hdr = {sh_reg[11:0], bit_in};

   // Next state; every step waits for a clock rise
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      sh_next = sh_reg;
      rd_next = rd_reg;
      hit_next = hit_reg;
      out_next = out_reg;
      oe_n_next = oe_n_reg;
      rds_next = 1'h0;
      wrs_next = 1'h0;
      addr_next = addr_reg;
      wd_next = wd_reg;
      if (mdc_rise) begin
         case (state_reg)
            PMB_PRE: begin
               // Count ones; a zero after enough is the start
               if (bit_in) begin
                  if (cnt_reg != PRE_LEN) begin
                     cnt_next = cnt_reg + 6'h01;
                  end
               end else if (cnt_reg == PRE_LEN) begin
                  state_next = PMB_HDR;
                  cnt_next = 6'h00;
               end else begin
                  cnt_next = 6'h00;
               end
            end
            PMB_HDR: begin
               sh_next = {sh_reg[14:0], bit_in};
               cnt_next = cnt_reg + 6'h01;
               if (cnt_reg == HDR_LAST) begin
                  cnt_next = 6'h00;
                  // Bad start or opcode drops the frame
                  if (hdr[12] && (hdr[11:10] == OP_READ ||
                      hdr[11:10] == OP_WRITE)) begin
                     state_next = PMB_TA;
                     rd_next = (hdr[11:10] == OP_READ);
                     hit_next = (hdr[9:5] == phy_addr);
                     addr_next = hdr[4:0];
                     rds_next = (hdr[11:10] == OP_READ) &&
                                (hdr[9:5] == phy_addr);
                  end else begin
                     state_next = PMB_PRE;
                  end
               end
            end
            PMB_TA: begin
               cnt_next = cnt_reg + 6'h01;
               if (cnt_reg == 6'h00) begin
                  // Second turnaround bit is driven low
                  if (rd_reg && hit_reg) begin
                     oe_n_next = 1'h0;
                     out_next = 1'h0;
                  end
               end else begin
                  state_next = PMB_DATA;
                  cnt_next = 6'h00;
                  if (rd_reg && hit_reg) begin
                     out_next = bus.rdata[15];
                     sh_next = {bus.rdata[14:0], 1'h0};
                  end
               end
            end
            PMB_DATA: begin
               sh_next = {sh_reg[14:0], bit_in};
               out_next = sh_reg[15];
               cnt_next = cnt_reg + 6'h01;
               if (cnt_reg == DATA_LAST) begin
                  state_next = PMB_PRE;
                  cnt_next = 6'h00;
                  oe_n_next = 1'h1;
                  if (!rd_reg && hit_reg) begin
                     wrs_next = 1'h1;
                     wd_next = {sh_reg[14:0], bit_in};
                  end
               end
            end
            default: begin
               state_next = PMB_PRE;
               cnt_next = 6'h00;
            end
         endcase
      end
   end

   // Register the frame state
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= PMB_PRE;
         cnt_reg <= 6'h00;
         sh_reg <= 16'h0000;
         rd_reg <= 1'h0;
         hit_reg <= 1'h0;
         out_reg <= 1'h1;
         oe_n_reg <= 1'h1;
         rds_reg <= 1'h0;
         wrs_reg <= 1'h0;
         addr_reg <= 5'h00;
         wd_reg <= 16'h0000;
      end else if (ce) begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         sh_reg <= sh_next;
         rd_reg <= rd_next;
         hit_reg <= hit_next;
         out_reg <= out_next;
         oe_n_reg <= oe_n_next;
         rds_reg <= rds_next;
         wrs_reg <= wrs_next;
         addr_reg <= addr_next;
         wd_reg <= wd_next;
      end
   end

   assign mdio_o = out_reg;
   assign mdio_oe_n = oe_n_reg;
   assign bus.rd_stb = rds_reg;
   assign bus.wr_stb = wrs_reg;
   assign bus.addr = addr_reg;
   assign bus.wdata = wd_reg;

   // Pin driven only during an addressed read reply
   property p_oe_read;
      @(posedge clk) disable iff (rst)
      !oe_n_reg |-> rd_reg && hit_reg && state_reg != PMB_PRE;
   endproperty
   a_oe_read: assert property (p_oe_read)
      else $error("pin driven outside read reply");

   // A write strobe closes the frame
   property p_wr_end;
      @(posedge clk) disable iff (rst)
      wrs_reg |-> state_reg == PMB_PRE && !rd_reg && hit_reg;
   endproperty
   a_wr_end: assert property (p_wr_end)
      else $error("write strobe outside frame end");

endmodule

/* File: tb/pmb_station.sv */
// Management station model driving serial frames
`timescale 1ns/1ps
module pmb_station
   import pmb_pkg::*;
(
   input wire logic clk,
   input wire logic dev_o,
   input wire logic dev_oe_n,
   output logic mdc,
   output logic mdio
);
   logic drv = 1'b1; // Station drive, high when released
   initial mdc = 1'b0;
   // Open drain wire with pull-up; device pulls when enable low
   assign mdio = drv & (dev_oe_n | dev_o);
   // One frame; clock stands still low outside frames
   task automatic xfer(input logic [1:0] op, input logic [4:0] r,
         input logic [15:0] wd, output logic [15:0] rd);
      logic [63:0] f;
      f = {32'hffffffff, 2'b01, op, 5'h01, r, 2'b10, wd};
      // Read releases the turnaround and data
      if (op == OP_READ) f[17:0] = 18'h3ffff;
      for (int i = 63; i >= 0; i--) begin
         @(posedge clk) drv <= f[i];
         repeat (4) @(posedge clk);
         mdc <= 1'b1;
         @(posedge clk) rd = {rd[14:0], mdio};
         repeat (3) @(posedge clk);
         mdc <= 1'b0;
      end
      @(posedge clk) drv <= 1'b1;
      repeat (8) @(posedge clk);
   endtask
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the management register bank
`timescale 1ns/1ps
module tb_top
   import pmb_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic fx = 1'b0;
   logic ce = 1'b1, an_pin = 1'b1, txen = 1'b1, neg_dup = 1'b1;
   logic neg_spd = 1'b0; // Negotiated speed, 10 until changed
   logic [3:0] txd = 4'h0;
   logic mdc, mdio, mdo, oe_n, rxdv, loop, spd, dup, pdn, busy;
   logic [3:0] rxd;
   logic [15:0] rv;
   int error_cnt = 0;
   int checked = 0;
   int busy_len = 0; // Cycles seen with the reset interval running
   int busy_at = 0; // Count snapshot; counter has one driver only
   // Id values are arbitrary
   logic [15:0] exp_tab [8] = '{16'h3100, 16'h7849, 16'h5a5a,
      16'ha5a5, 16'h01e1, 16'h0080, 16'h0000, 16'h0000};
   initial forever #5 clk = ~clk;
   always @(posedge clk) if (busy === 1'b1) busy_len <= busy_len + 1;
   pmb_station st (.clk(clk), .dev_o(mdo), .dev_oe_n(oe_n), .mdc(mdc),
      .mdio(mdio));
   pmb_basic_control #(.ID_HIGH(16'h5a5a), .ID_LOW(16'ha5a5)) dut (
      .SYS_CLK(clk), .RESET(rst), .CE(ce), .MDC(mdc), .MDIO_I(mdio),
      .MDIO_O(mdo), .MDIO_OE_N(oe_n), .PHY_ADDR(5'h01), .AN_PIN_EN(an_pin),
      .FX_MODE(fx), .NEG_SPEED_100(neg_spd), .NEG_FULL_DUPLEX(neg_dup),
      .TXD(txd), .TXEN(txen), .RXD_PHY(4'h3), .RXDV_PHY(1'b1), .RXD(rxd),
      .RXDV(rxdv), .LOOPBACK(loop), .SPEED_100(spd), .FULL_DUPLEX(dup),
      .POWER_DOWN(pdn), .SRST_BUSY(busy));
   // Compare and count
   task automatic chk(input logic [15:0] seen, input logic [15:0] want);
      checked++;
      if (seen !== want) begin
         error_cnt++;
         $display("wrong value at %0t: got %h want %h", $time, seen, want);
      end
   endtask
   task automatic wr(input logic [4:0] r, input logic [15:0] d);
      logic [15:0] x;
      st.xfer(OP_WRITE, r, d, x);
   endtask
   task automatic stop_test;
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Hang guard, about four times the expected run
   initial begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      stop_test;
   end
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      // Defaults, then one unmapped number; speed bit reads forced value
      for (int i = 0; i < 8; i++) begin
         st.xfer(OP_READ, 5'(i), 16'hffff, rv);
         chk(rv, exp_tab[i]);
      end
      chk({15'h0, spd}, 16'h0000);
      wr(REG_CTRL, 16'h0000);
      chk(16'(busy_len), 16'h0000);
      chk({15'h0, spd}, 16'h0000);
      wr(REG_CTRL, 16'h2000);
      chk({15'h0, spd}, 16'h0001);
      // Loopback on, nibble comes back one cycle later
      wr(REG_CTRL, 16'h4000);
      @(posedge clk) txd <= 4'ha;
      repeat (2) @(negedge clk);
      chk({11'h0, loop, rxd}, 16'h001a);
      st.xfer(OP_READ, REG_CTRL, 16'hffff, rv);
      chk(rv, 16'h4000);
      wr(REG_CTRL, 16'h0000);
      repeat (2) @(negedge clk);
      chk({11'h0, loop, rxd}, 16'h0003);
      // Software reset with loopback also set in the same write
      wr(REG_ADV, 16'h0041);
      busy_at = busy_len;
      wr(REG_CTRL, 16'hc000);
      repeat (120) @(posedge clk);
      chk(16'(busy_len - busy_at), 16'(SRST_CYCLES));
      st.xfer(OP_READ, REG_CTRL, 16'hffff, rv);
      chk(rv, 16'h3100);
      st.xfer(OP_READ, REG_ADV, 16'hffff, rv);
      chk(rv, 16'h01e1);
      // Fiber mode pins the speed bit
      fx <= 1'b1;
      wr(REG_CTRL, 16'h0000);
      st.xfer(OP_READ, REG_CTRL, 16'hffff, rv);
      chk(rv, 16'h2000);
      chk({15'h0, spd}, 16'h0001);
      // Enable low freezes the loopback path, high lets it follow
      fx <= 1'b0;
      wr(REG_CTRL, 16'h4000);
      @(posedge clk) ce <= 1'b0;
      txd <= 4'h5;
      txen <= 1'b0;
      repeat (3) @(negedge clk);
      chk({11'h0, rxdv, rxd}, 16'h001a);
      @(posedge clk) ce <= 1'b1;
      repeat (2) @(negedge clk);
      chk({11'h0, rxdv, rxd}, 16'h0005);
      // Chip reset in mid run ends loopback and restores defaults
      @(posedge clk) rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(negedge clk);
      chk({8'h0, busy, pdn, loop, rxdv, rxd}, 16'h0013);
      chk({14'h0, dup, spd}, 16'h0002);
      st.xfer(OP_READ, REG_CTRL, 16'hffff, rv);
      chk(rv, 16'h3100);
      // Strap low: negotiation off and the enable bit deaf
      an_pin <= 1'b0;
      neg_spd <= 1'b1;
      wr(REG_CTRL, 16'h0800);
      st.xfer(OP_READ, REG_CTRL, 16'hffff, rv);
      chk(rv, 16'h1800);
      chk({14'h0, pdn, spd}, 16'h0002);
      // Negotiation on: results drive outputs, speed bit reads forced
      an_pin <= 1'b1;
      neg_dup <= 1'b0;
      wr(REG_CTRL, 16'h1100);
      chk({14'h0, dup, spd}, 16'h0001);
      st.xfer(OP_READ, REG_CTRL, 16'hffff, rv);
      chk(rv, 16'h1000);
      stop_test;
   end
endmodule
